// ===== src/pitc_pkg.sv
/*
 * Constants, field layout and carrier types for the paired interval timer with capture.
 * Assumes a 32-bit APB slave on a single clock; oscillator inputs are asynchronous pins.
 */
`default_nettype none

package pitc_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_LOW_CMP   = 8'h00;
    localparam logic [7:0] OFF_HIGH_CMP  = 8'h04;
    localparam logic [7:0] OFF_CTL       = 8'h08;
    localparam logic [7:0] OFF_DIV_LOW   = 8'h0C;
    localparam logic [7:0] OFF_DIV_HIGH  = 8'h10;
    localparam logic [7:0] OFF_CSEL      = 8'h14;
    localparam logic [7:0] OFF_CC        = 8'h18;
    localparam logic [7:0] OFF_CAP_HOLD  = 8'h1C;
    localparam logic [7:0] OFF_STATUS    = 8'h20;
    localparam logic [7:0] OFF_COUNTERS  = 8'h24;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned CTL_LOW_RUN    = 0;
    localparam int unsigned CTL_CH1_RUN    = 1;
    localparam int unsigned CTL_HIGH_RUN   = 2;
    localparam int unsigned CTL_CH3_RUN    = 3;
    localparam int unsigned CTL_MODE_LSB   = 4;
    localparam int unsigned DIV_EVEN_LSB   = 0;
    localparam int unsigned DIV_ODD_LSB    = 4;
    localparam int unsigned CSEL_COUNT_LSB = 0;
    localparam int unsigned CSEL_CAP_LSB   = 4;
    localparam int unsigned CC_CAPTURE_ENABLE_BIT       = 0;
    localparam int unsigned CC_CLEAR       = 1;
    localparam int unsigned CC_TRIG_LSB    = 4;
    localparam int unsigned ST_CAPTURED    = 0;
    localparam int unsigned ST_LOW_MATCH   = 1;
    localparam int unsigned ST_HIGH_MATCH  = 2;
    localparam int unsigned ST_OVERRUN     = 3;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [15:0] RST_CMP      = 16'hFFFF;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [1:0]  MODE_CAPTURE = 2'h1;
    localparam logic [6:0]  PRE_FULL     = 7'h7F;

    typedef enum logic [1:0] {
        TRIG_HIGH_MATCH,
        TRIG_PIN_RISE,
        TRIG_PIN_FALL,
        TRIG_NONE
    } pitc_trig_e;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] low_cmp;
        logic [15:0] high_cmp;
        logic [7:0]  ctl;
        logic [7:0]  div_low;
        logic [7:0]  div_high;
        logic [7:0]  csel;
        logic [7:0]  cc;
    } pitc_cfg_s;

    typedef struct packed {
        logic captured;
        logic low_match;
        logic high_match;
        logic overrun;
    } pitc_evt_s;

endpackage : pitc_pkg

`default_nettype wire

// ===== src/pitc_top.sv
/*
 * Paired interval timer with 16-bit capture: low pair counts a selected count clock,
 * high pair counts a selected capture clock and its compare match can capture the low count.
 * Assumes osc_in and cap_trig_in are asynchronous pins, each far slower than mclk / 2.
 */
`default_nettype none

module pitc_top (
    // Clock, reset and enable
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Oscillator and trigger pins
    input  wire logic [7:0]  osc_in,
    input  wire logic        cap_trig_in,
    // Capture event
    output var  logic        capture_pulse
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [8:0] sync1_q, sync2_q, sync3_q;
    logic [8:0] pin_rise, pin_fall;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else if (ce) begin
            sync1_q <= {cap_trig_in, osc_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Edges come from the second and third stages only, never the first.
    assign pin_rise = sync2_q & ~sync3_q;
    assign pin_fall = ~sync2_q & sync3_q;

    // ****************************************************************
    // Divider mask: a field value n divides the source by 2 to the n
    // ****************************************************************
    // A tick needs the n low prescaler bits all at one, once every 2 to the n edges.
    // A field of zero gives an empty mask, so every source edge is a tick.
    function automatic logic [6:0] div_mask(input logic [2:0] n);
        div_mask = pitc_pkg::PRE_FULL >> (3'd7 - n);
    endfunction : div_mask

    // ****************************************************************
    // State
    // ****************************************************************
    pitc_pkg::pitc_cfg_s cfg_q, cfg_d;
    pitc_pkg::pitc_evt_s sts_q, sts_d;
    logic [15:0] low_cnt_q, low_cnt_d;
    logic [15:0] high_cnt_q, high_cnt_d;
    logic [15:0] hold_q, hold_d;
    logic [6:0]  pre_low_q, pre_low_d;
    logic [6:0]  pre_high_q, pre_high_d;
    logic        cap_pulse_q, cap_pulse_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;

    // ****************************************************************
    // Decoded controls
    // ****************************************************************
    logic       low_run, high_run, capture_mode, clear_after;
    logic [1:0] mode_field;
    logic [2:0] div0, div2, count_sel, cap_sel;
    logic [1:0] trig_sel;
    logic       count_src_tick, cap_src_tick;
    logic       low_tick, high_tick, low_match, high_match, cap_ev;

    assign low_run     = cfg_q.ctl[pitc_pkg::CTL_LOW_RUN];
    assign high_run    = cfg_q.ctl[pitc_pkg::CTL_HIGH_RUN];
    assign mode_field  = cfg_q.ctl[pitc_pkg::CTL_MODE_LSB +: 2];
    assign div0        = cfg_q.div_low[pitc_pkg::DIV_EVEN_LSB +: 3];
    assign div2        = cfg_q.div_high[pitc_pkg::DIV_EVEN_LSB +: 3];
    assign count_sel   = cfg_q.csel[pitc_pkg::CSEL_COUNT_LSB +: 3];
    assign cap_sel     = cfg_q.csel[pitc_pkg::CSEL_CAP_LSB +: 3];
    assign trig_sel    = cfg_q.cc[pitc_pkg::CC_TRIG_LSB +: 2];
    assign clear_after = cfg_q.cc[pitc_pkg::CC_CLEAR];
    // Capture needs both the mode field at 01b and the capture enable bit.
    assign capture_mode = (mode_field == pitc_pkg::MODE_CAPTURE)
                        && cfg_q.cc[pitc_pkg::CC_CAPTURE_ENABLE_BIT];

    assign count_src_tick = pin_rise[count_sel];
    assign cap_src_tick   = pin_rise[cap_sel];

    // Prescaled ticks; a divider field of zero passes every source edge.
    assign low_tick  = low_run && count_src_tick
                     && ((pre_low_q & div_mask(div0)) == div_mask(div0));
    assign high_tick = high_run && cap_src_tick
                     && ((pre_high_q & div_mask(div2)) == div_mask(div2));
    assign low_match  = low_tick && (low_cnt_q == cfg_q.low_cmp);
    assign high_match = high_tick && (high_cnt_q == cfg_q.high_cmp);

    // ****************************************************************
    // Capture trigger selection
    // ****************************************************************
    always_comb begin
        case (pitc_pkg::pitc_trig_e'(trig_sel))
            pitc_pkg::TRIG_HIGH_MATCH: cap_ev = capture_mode && high_match;
            pitc_pkg::TRIG_PIN_RISE:   cap_ev = capture_mode && pin_rise[8];
            pitc_pkg::TRIG_PIN_FALL:   cap_ev = capture_mode && pin_fall[8];
            default:                   cap_ev = 1'b0;
        endcase
    end

    // ****************************************************************
    // Counters and capture
    // ****************************************************************
    always_comb begin
        pre_low_d   = pre_low_q;
        pre_high_d  = pre_high_q;
        low_cnt_d   = low_cnt_q;
        high_cnt_d  = high_cnt_q;
        hold_d      = hold_q;
        cap_pulse_d = cap_ev;
        if (low_run && count_src_tick) begin
            pre_low_d = pre_low_q + 7'd1;
        end
        if (high_run && cap_src_tick) begin
            pre_high_d = pre_high_q + 7'd1;
        end
        // In capture mode the low pair runs free; otherwise it reloads on its match.
        if (low_tick) begin
            if (!capture_mode && low_match) begin
                low_cnt_d = 16'h0000;
            end else begin
                low_cnt_d = low_cnt_q + 16'd1;
            end
        end
        // The high pair always restarts on match, which sets the trigger interval.
        if (high_tick) begin
            if (high_match) begin
                high_cnt_d = 16'h0000;
            end else begin
                high_cnt_d = high_cnt_q + 16'd1;
            end
        end
        if (cap_ev) begin
            hold_d = low_cnt_q;
            if (clear_after) begin
                low_cnt_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pre_low_q   <= '0;
            pre_high_q  <= '0;
            low_cnt_q   <= '0;
            high_cnt_q  <= '0;
            hold_q      <= '0;
            cap_pulse_q <= 1'b0;
        end else if (ce) begin
            pre_low_q   <= pre_low_d;
            pre_high_q  <= pre_high_d;
            low_cnt_q   <= low_cnt_d;
            high_cnt_q  <= high_cnt_d;
            hold_q      <= hold_d;
            cap_pulse_q <= cap_pulse_d;
        end
    end

    // ****************************************************************
    // APB slave: one wait state, writes and reads complete with pready
    // ****************************************************************
    logic        acc_done, wr_done;
    logic [31:0] rd_word;
    logic        addr_bad;

    assign acc_done = psel && penable && pready_q;
    assign wr_done  = acc_done && pwrite && !pslverr_q;

    always_comb begin
        rd_word  = 32'h0000_0000;
        addr_bad = 1'b0;
        if (paddr == pitc_pkg::OFF_LOW_CMP) begin
            rd_word = {16'h0000, cfg_q.low_cmp};
        end else if (paddr == pitc_pkg::OFF_HIGH_CMP) begin
            rd_word = {16'h0000, cfg_q.high_cmp};
        end else if (paddr == pitc_pkg::OFF_CTL) begin
            rd_word = {24'h00_0000, cfg_q.ctl};
        end else if (paddr == pitc_pkg::OFF_DIV_LOW) begin
            rd_word = {24'h00_0000, cfg_q.div_low};
        end else if (paddr == pitc_pkg::OFF_DIV_HIGH) begin
            rd_word = {24'h00_0000, cfg_q.div_high};
        end else if (paddr == pitc_pkg::OFF_CSEL) begin
            rd_word = {24'h00_0000, cfg_q.csel};
        end else if (paddr == pitc_pkg::OFF_CC) begin
            rd_word = {24'h00_0000, cfg_q.cc};
        end else if (paddr == pitc_pkg::OFF_CAP_HOLD) begin
            rd_word = {16'h0000, hold_q};
        end else if (paddr == pitc_pkg::OFF_STATUS) begin
            rd_word = {28'h000_0000, sts_q.overrun, sts_q.high_match,
                       sts_q.low_match, sts_q.captured};
        end else if (paddr == pitc_pkg::OFF_COUNTERS) begin
            rd_word = {high_cnt_q, low_cnt_q};
        end else begin
            addr_bad = 1'b1;
        end
    end

    always_comb begin
        pready_d  = 1'b0;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = addr_bad;
            prdata_d  = pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_comb begin
        cfg_d = cfg_q;
        if (wr_done) begin
            if (paddr == pitc_pkg::OFF_LOW_CMP) begin
                cfg_d.low_cmp = pwdata[15:0];
            end else if (paddr == pitc_pkg::OFF_HIGH_CMP) begin
                cfg_d.high_cmp = pwdata[15:0];
            end else if (paddr == pitc_pkg::OFF_CTL) begin
                cfg_d.ctl = pwdata[7:0];
            end else if (paddr == pitc_pkg::OFF_DIV_LOW) begin
                cfg_d.div_low = pwdata[7:0];
            end else if (paddr == pitc_pkg::OFF_DIV_HIGH) begin
                cfg_d.div_high = pwdata[7:0];
            end else if (paddr == pitc_pkg::OFF_CSEL) begin
                cfg_d.csel = pwdata[7:0];
            end else if (paddr == pitc_pkg::OFF_CC) begin
                cfg_d.cc = pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Sticky status, cleared by writing one; a new event beats the clear
    // ****************************************************************
    logic [3:0] clr_bits;

    assign clr_bits = (wr_done && paddr == pitc_pkg::OFF_STATUS) ? pwdata[3:0] : 4'h0;

    always_comb begin
        sts_d.captured   = cap_ev
                         || (sts_q.captured && !clr_bits[pitc_pkg::ST_CAPTURED]);
        sts_d.low_match  = low_match
                         || (sts_q.low_match && !clr_bits[pitc_pkg::ST_LOW_MATCH]);
        sts_d.high_match = high_match
                         || (sts_q.high_match && !clr_bits[pitc_pkg::ST_HIGH_MATCH]);
        // Overrun warns that a held value was replaced before software took it.
        sts_d.overrun    = (cap_ev && sts_q.captured)
                         || (sts_q.overrun && !clr_bits[pitc_pkg::ST_OVERRUN]);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_q.low_cmp  <= pitc_pkg::RST_CMP;
            cfg_q.high_cmp <= pitc_pkg::RST_CMP;
            cfg_q.ctl      <= pitc_pkg::RST_BYTE;
            cfg_q.div_low  <= pitc_pkg::RST_BYTE;
            cfg_q.div_high <= pitc_pkg::RST_BYTE;
            cfg_q.csel     <= pitc_pkg::RST_BYTE;
            cfg_q.cc       <= pitc_pkg::RST_BYTE;
            sts_q          <= '0;
            prdata_q       <= '0;
            pready_q       <= 1'b0;
            pslverr_q      <= 1'b0;
        end else if (ce) begin
            cfg_q     <= cfg_d;
            sts_q     <= sts_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign capture_pulse = cap_pulse_q;

endmodule : pitc_top

`default_nettype wire

// ===== sim/pitc_osc_model.sv
/*
 * Free-running model of the on-chip oscillators that feed the timer's osc_in pins.
 * Assumes the bench clock has rising edges at 2 ns + 4 ns * k, so no oscillator edge lands on one.
 */
`default_nettype none

module pitc_osc_model (
    // Oscillator pins
    output var logic [7:0] osc_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Oscillators
    // ****************************************************************
    // Pin 1 is the fast count clock, 40 ns per period; one interval run divides it by two.
    // Pin 2 is the slow capture clock, 400 ns per period.
    // The phases keep fast and slow edges at least one bench cycle apart.
    // Coincident edges would make the captured count depend on the synchroniser race.
    localparam int HALF [8]  = '{50, 20, 200, 40, 50, 50, 50, 50};
    localparam int PHASE [8] = '{3, 1, 9, 5, 3, 3, 3, 3};

    for (genvar i = 0; i < 8; i++) begin : g_osc
        initial begin
            osc_in[i] = 1'b0;
            #(PHASE[i]);
            forever begin
                osc_in[i] = ~osc_in[i];
                #(HALF[i]);
            end
        end
    end

endmodule : pitc_osc_model

`default_nettype wire

// ===== sim/pitc_top_sva.sv
/*
 * Checker for pitc_top: APB answer timing, error and read-data relations, capture pulse shape.
 * Assumes it is bound to pitc_top and sees only that module's ports.
 */
`default_nettype none

module pitc_top_sva (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        ce,
    // APB
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and events
    input wire logic [7:0]  osc_in,
    input wire logic        cap_trig_in,
    input wire logic        capture_pulse
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    AST_ANSWER_NEXT: assert property (psel && penable && !pready && ce |=> pready)
        else $error("pready did not follow the first access edge");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_WRITE_DATA_ZERO: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("prdata not zero on a write");
    AST_UNMAPPED: assert property (pready && paddr > 8'h24 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (pready && paddr <= 8'h24 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (pready && !pwrite && paddr <= 8'h18 |-> prdata[31:16] == 16'h0)
        else $error("upper bits of a configuration register read nonzero");
    AST_PRDATA_HOLD: assert property ($changed(prdata) |-> pready)
        else $error("prdata changed without pready");
    AST_CAP_PULSE_ONE: assert property (capture_pulse |=> !capture_pulse)
        else $error("capture pulse longer than one cycle");

    COV_CAPTURE: cover property (capture_pulse);
    COV_REFUSED: cover property (pready && pslverr);
    COV_HOLD_READ: cover property (pready && !pwrite && paddr == 8'h1C);

endmodule : pitc_top_sva

bind pitc_top pitc_top_sva u_sva (.mclk, .rstn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .osc_in, .cap_trig_in, .capture_pulse);

`default_nettype wire

// ===== sim/paired_interval_timer_capture_test.sv
/*
 * Self-checking bench for pitc_top: register access, captured interval counts, trigger
 * selection and the capture flag. Assumes pitc_osc_model drives every oscillator pin.
 */
`default_nettype none

module paired_interval_timer_capture_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk, rstn, ce, psel, penable, pwrite, pready, pslverr, cap_trig_in;
    logic        capture_pulse, err;
    logic [7:0]  paddr, osc_in;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] h1;
    logic [31:0] c1;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          pulse_cnt = 0;
    int          cyc = 0;
    int          last_cyc = 0;
    int          gap = 0;
    int          base;

    localparam logic [7:0]  OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    // The control word keeps both run bits clear, so no counter runs past a later, smaller compare.
    localparam logic [31:0] WV [7]   = '{32'hFFFF_1234, 32'h0001_00FE, 32'h0000_003A,
        32'h0000_0005, 32'h0000_0000, 32'h0000_0076, 32'h0000_0033};
    localparam logic [31:0] EV [7]   = '{32'h0000_1234, 32'h0000_00FE, 32'h0000_003A,
        32'h0000_0005, 32'h0000_0000, 32'h0000_0076, 32'h0000_0033};
    localparam logic [31:0] CMPV [5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h0000_007F};
    localparam logic [31:0] DIVV [5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] CSV [5]  = '{32'h21, 32'h21, 32'h23, 32'h31, 32'h21};
    localparam logic [31:0] EXPV [5] = '{32'h14, 32'h0A, 32'h0A, 32'h04, 32'h0000_0500};
    localparam logic [31:0] GAPV [5] = '{32'hC8, 32'hC8, 32'hC8, 32'h28, 32'h0000_3200};
    localparam logic [31:0] CTLP [6] = '{32'h15, 32'h15, 32'h15, 32'h05, 32'h15, 32'h11};
    localparam logic [31:0] CCP [6]  = '{32'h13, 32'h23, 32'h33, 32'h03, 32'h02, 32'h03};
    localparam logic [31:0] NP [6]   = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

    pitc_top DUT (.mclk, .rstn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .osc_in, .cap_trig_in, .capture_pulse);
    pitc_osc_model u_osc (.osc_in);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (capture_pulse === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
            gap       <= cyc - last_cyc;
            last_cyc  <= cyc;
        end
    end

    // ****************************************************************
    // Access and check tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // The request stands until pready is sampled high; only the watchdog ends a hang.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask : rdchk

    task automatic wait_pulses(input int n);
        int t = pulse_cnt + n;
        int k = 0;
        while (pulse_cnt < t && k < 30000) begin
            @(posedge mclk);
            k++;
        end
        @(posedge mclk);
        if (k >= 30000) chk("capture wait", 32'h1, 32'h0);
    endtask : wait_pulses

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; cap_trig_in = 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rdchk(OFFS[0], 32'h0000_FFFF, "low compare reset");
        rdchk(OFFS[1], 32'h0000_FFFF, "high compare reset");
        for (int i = 2; i < 7; i++) rdchk(OFFS[i], 32'h0, "config reset");
        for (int i = 0; i < 7; i++) apb(1'b1, OFFS[i], WV[i]);
        for (int i = 0; i < 7; i++) rdchk(OFFS[i], EV[i], "register readback");
        apb(1'b1, 8'h40, 32'h0000_FFFF);
        chk("unmapped refused", 32'h1, {31'h0, err});
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped data", 32'h0, rdat);
        $display("test registers done");
        // Hold mode: successive captures differ by one full interval.
        apb(1'b1, pitc_pkg::OFF_DIV_LOW, 32'h0);
        apb(1'b1, pitc_pkg::OFF_HIGH_CMP, 32'h1);
        apb(1'b1, pitc_pkg::OFF_CSEL, 32'h21);
        apb(1'b1, pitc_pkg::OFF_CC, 32'h1);
        apb(1'b1, pitc_pkg::OFF_CTL, 32'h15);
        wait_pulses(1);
        apb(1'b0, pitc_pkg::OFF_CAP_HOLD, 32'h0);
        h1 = rdat[15:0];
        wait_pulses(1);
        apb(1'b0, pitc_pkg::OFF_CAP_HOLD, 32'h0);
        chk("hold step", 32'h14, {16'h0, rdat[15:0] - h1});
        rdchk(pitc_pkg::OFF_STATUS, 32'hD, "status flags");
        apb(1'b1, pitc_pkg::OFF_STATUS, 32'h1);
        apb(1'b0, pitc_pkg::OFF_STATUS, 32'h0);
        chk("captured flag cleared", 32'h0, {31'h0, rdat[0]});
        $display("test hold and flag done");
        for (int r = 0; r < 5; r++) begin
            apb(1'b1, pitc_pkg::OFF_HIGH_CMP, CMPV[r]);
            apb(1'b1, pitc_pkg::OFF_DIV_LOW, DIVV[r]);
            apb(1'b1, pitc_pkg::OFF_CSEL, CSV[r]);
            apb(1'b1, pitc_pkg::OFF_CC, 32'h3);
            wait_pulses(2);
            rdchk(pitc_pkg::OFF_CAP_HOLD, EXPV[r], "captured count");
            chk("capture spacing", GAPV[r], gap);
            $display("test interval %0d done", r);
        end
        apb(1'b1, pitc_pkg::OFF_HIGH_CMP, 32'h1);
        // Frozen by ce, the capture logic must hold off a pulse due every 200 cycles.
        wait_pulses(1);
        base = pulse_cnt;
        ce <= 1'b0;
        repeat (1000) @(posedge mclk);
        chk("frozen pulses", 32'h0, pulse_cnt - base);
        ce <= 1'b1;
        wait_pulses(1);
        $display("test clock enable done");
        for (int r = 0; r < 6; r++) begin
            apb(1'b1, pitc_pkg::OFF_CTL, CTLP[r]);
            apb(1'b1, pitc_pkg::OFF_CC, CCP[r]);
            repeat (4) @(posedge mclk);
            base = pulse_cnt;
            repeat (20) @(posedge mclk);
            cap_trig_in <= 1'b1;
            repeat (100) @(posedge mclk);
            cap_trig_in <= 1'b0;
            repeat (400) @(posedge mclk);
            chk("trigger pulses", NP[r], pulse_cnt - base);
            $display("test trigger %0d done", r);
        end
        // High pair stopped, low pair free: two reads 100 cycles apart span 10 fast edges.
        apb(1'b0, pitc_pkg::OFF_COUNTERS, 32'h0);
        c1 = rdat;
        repeat (96) @(posedge mclk);
        apb(1'b0, pitc_pkg::OFF_COUNTERS, 32'h0);
        chk("high pair stopped", {16'h0, c1[31:16]}, {16'h0, rdat[31:16]});
        chk("low pair step", 32'h0000_000A, {16'h0, rdat[15:0] - c1[15:0]});
        $display("test counters done");
        give_verdict();
    end

    initial begin
        #200000;
        chk("watchdog", 32'h0, 32'h1);
        give_verdict();
    end

endmodule : paired_interval_timer_capture_test

`default_nettype wire
